/* rtl/serial_port_consts.svh */
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define OFS_DATA 32'h0000_0000
`define OFS_STATUS_A 32'h0000_0004
`define OFS_CONTROL_B 32'h0000_0008
`define OFS_FORMAT 32'h0000_000C
`define OFS_BAUD 32'h0000_0010
`define RST_CONTROL_B 8'h00
`define RST_FORMAT 8'h86
`define RST_BAUD 12'h000
`define POS_REG_SELECT 7
`define POS_TX_COMPLETE 6
`define OS_NORMAL 5'h10
`define OS_DOUBLE 5'h08
`define OS_SYNC 5'h02
`define SIZE_NINE 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/serial_port_pkg.sv */
package serial_port_pkg;
   typedef struct packed {
      logic rx_complete_irq_en;
      logic tx_complete_irq_en;
      logic tx_empty_irq_en;
      logic receiver_enable;
      logic transmitter_enable;
      logic char_size_high;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
   } control_b_type;
   typedef struct packed {
      logic reg_select;
      logic sync_mode_select;
      logic [1:0] parity_mode;
      logic stop_two;
      logic [1:0] char_size_low;
      logic clock_polarity;
   } frame_format_type;
   typedef struct packed {
      logic ninth;
      logic [7:0] data;
      logic fe;
      logic pe;
   } rx_entry_type;
   typedef struct packed {
      logic [3:0] nbits;
      logic par_en;
      logic par_odd;
      logic two_stop;
   } frame_cfg_type;
   typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_type;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10, RX_STOP = 2'b11
   } rx_state_type;
endpackage

/* rtl/serial_tx_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_tx_shift
   import serial_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic os_tick,
   input wire logic [4:0] os_len,
   input wire frame_cfg_type cfg,
   input wire logic load,
   input wire logic [8:0] load_data,
   output logic idle,
   output logic done,
   output logic txd
);
   tx_state_type state_q;
   logic [12:0] frame_d;
   logic [12:0] shift_q;
   logic [3:0] bits_q;
   logic [4:0] os_q;
   logic par;
   always_comb begin
      frame_d = 13'h1FFF;
      frame_d[0] = 1'b0;
      par = cfg.par_odd;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < cfg.nbits) begin
            frame_d[i + 1] = load_data[i];
            par = par ^ load_data[i];
         end
      end
      if (cfg.par_en) begin
         frame_d[cfg.nbits + 4'h1] = par;
      end
   end
   assign idle = (state_q == TX_IDLE);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= TX_IDLE;
         shift_q <= 13'h1FFF;
         bits_q <= 4'h0;
         os_q <= 5'h00;
         txd <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_q)
            TX_IDLE: begin
               if (load) begin
                  shift_q <= frame_d;
                  // one or two stop bits
                  bits_q <= cfg.nbits + 4'h2 + {3'h0, cfg.par_en}
                     + {3'h0, cfg.two_stop};
                  os_q <= 5'h00;
                  txd <= frame_d[0];
                  state_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (os_tick) begin
                  if (os_q == os_len - 5'h01) begin
                     os_q <= 5'h00;
                     if (bits_q == 4'h1) begin
                        state_q <= TX_IDLE;
                        done <= 1'b1;
                        txd <= 1'b1;
                     end else begin
                        shift_q <= {1'b1, shift_q[12:1]};
                        txd <= shift_q[1];
                        bits_q <= bits_q - 4'h1;
                     end
                  end else begin
                     os_q <= os_q + 5'h01;
                  end
               end
            end
            default: state_q <= TX_IDLE;
         endcase
      end
   end
endmodule // serial_tx_shift
`default_nettype wire

/* rtl/serial_rx_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_rx_shift
   import serial_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic os_tick,
   input wire logic [4:0] os_len,
   input wire frame_cfg_type cfg,
   input wire logic enable,
   input wire logic rxd,
   output logic start_seen,
   output logic valid,
   output rx_entry_type entry,
   output logic stop_bit
);
   rx_state_type state_q;
   logic [4:0] os_q;
   logic [3:0] idx_q;
   logic [9:0] sr_q;
   logic [8:0] mask;
   logic last_os;
   always_comb begin
      mask = 9'h000;
      for (int i = 0; i < 9; i++) begin
         mask[i] = (4'(i) < cfg.nbits);
      end
   end
   assign last_os = (os_q == os_len - 5'h01);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= RX_IDLE;
         os_q <= 5'h00;
         idx_q <= 4'h0;
         sr_q <= 10'h000;
         start_seen <= 1'b0;
         valid <= 1'b0;
         entry <= '0;
         stop_bit <= 1'b1;
      end else if (!enable) begin
         state_q <= RX_IDLE;
         start_seen <= 1'b0;
         valid <= 1'b0;
      end else begin
         start_seen <= 1'b0;
         valid <= 1'b0;
         case (state_q)
            RX_IDLE: begin
               if (os_tick && !rxd) begin
                  state_q <= RX_START;
                  os_q <= 5'h00;
                  idx_q <= 4'h0;
                  sr_q <= 10'h000;
                  start_seen <= 1'b1;
               end
            end
            RX_START: begin
               if (os_tick) begin
                  // mid start bit: a glitch drops back to idle
                  if (os_q == (os_len >> 1) - 5'h01) begin
                     os_q <= 5'h00;
                     state_q <= rxd ? RX_IDLE : RX_BITS;
                  end else begin
                     os_q <= os_q + 5'h01;
                  end
               end
            end
            RX_BITS: begin
               if (os_tick) begin
                  if (last_os) begin
                     os_q <= 5'h00;
                     sr_q[idx_q] <= rxd;
                     idx_q <= idx_q + 4'h1;
                     if (idx_q == cfg.nbits + {3'h0, cfg.par_en} - 4'h1) begin
                        state_q <= RX_STOP;
                     end
                  end else begin
                     os_q <= os_q + 5'h01;
                  end
               end
            end
            RX_STOP: begin
               if (os_tick) begin
                  if (last_os) begin
                     state_q <= RX_IDLE;
                     valid <= 1'b1;
                     stop_bit <= rxd;
                     entry.fe <= !rxd;
                     // short characters read back zero-filled
                     entry.data <= sr_q[7:0] & mask[7:0];
                     entry.ninth <= (cfg.nbits == 4'h9) & sr_q[8];
                     entry.pe <= cfg.par_en & ((^sr_q) != cfg.par_odd);
                  end else begin
                     os_q <= os_q + 5'h01;
                  end
               end
            end
            default: state_q <= RX_IDLE;
         endcase
      end
   end
endmodule // serial_rx_shift
`default_nettype wire

/* rtl/serial_port_control_status.sv */
// Notes on behaviour
// - receive-complete high while buffer holds data
// - receiver disable flushes buffer and error flags
// - tx-complete sets when shifter and buffer empty
// - tx-complete clears on service or written one
// - buffer-empty shows free tx buffer, set at reset
// - frame error when head's stop bit zero
// - overrun on start bit with everything full
// - parity error for head when checking enabled
// - double speed divides by 8 not 16
// - multiprocessor mode drops non-address frames
// - interrupt needs enable, global flag and flag
// - receiver enable takes over the receive pin
// - tx disable waits until nothing pending
// - ninth received bit readable, read it first
// - register select reads one, write needs one
// - mode bit zero async, one sync
// - parity field off, reserved, even, odd
// - stop select gives one or two stops
// - character size 5 to 9 bits
// - receive buffer two-entry fifo, advanced on access
// - data location writes tx, reads rx head
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port_control_status
   import serial_port_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rxd,
   output logic rx_pin_owned,
   output logic txd,
   output logic txd_oe,
   input wire logic global_irq_en,
   input wire logic tx_irq_ack,
   output logic rx_irq_req,
   output logic tx_irq_req,
   output logic empty_irq_req
);
   control_b_type ctrl_q;
   frame_format_type fmt_q;
   frame_cfg_type cfg;
   rx_entry_type fifo_q [2];
   rx_entry_type head, rx_entry, pend_q, push_entry;
   logic [11:0] baud_q, presc_q;
   logic [4:0] os_len;
   logic [2:0] csz;
   logic os_tick;
   logic double_speed_q, multiproc_q, txc_q, dor_q;
   logic tx_buf_full_q, tx_own_q, txd_q;
   logic [8:0] tx_buf_q;
   logic tx_idle, tx_done, tx_line, tx_load;
   logic rxd_s1, rxd_s2, rxd_s3, rxd_q;
   logic rx_valid, rx_start, rx_stop, rx_valid_f;
   logic [1:0] rx_count_q;
   logic wr_ptr_q, rd_ptr_q, pend_valid_q;
   logic push, pop, push_pend, rx_take;
   logic aw_hold_q, w_hold_q;
   logic [31:0] awaddr_q, wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go, wr_en, wr_map, rd_go, rd_map;
   logic wr_data, wr_status, wr_ctrl, wr_fmt, wr_baud;
   logic [31:0] rd_word;
   logic [7:0] status_rd;

   // frame setup shared by both directions
   assign csz = {ctrl_q.char_size_high, fmt_q.char_size_low};
   assign cfg.nbits = (csz == `SIZE_NINE) ? 4'h9 : {2'h1, csz[1:0]} + 4'h1;
   assign cfg.par_en = fmt_q.parity_mode[1];
   assign cfg.par_odd = fmt_q.parity_mode[0];
   assign cfg.two_stop = fmt_q.stop_two;

   // baud prescaler; writing the divisor restarts it at once
   always_ff @(posedge aclk) begin
      if (!aresetn || wr_baud || presc_q == baud_q) begin
         presc_q <= 12'h000;
      end else begin
         presc_q <= presc_q + 12'h001;
      end
   end
   assign os_tick = (presc_q == baud_q);
   always_comb begin
      if (fmt_q.sync_mode_select) begin
         os_len = `OS_SYNC;
      end else if (double_speed_q) begin
         os_len = `OS_DOUBLE;
      end else begin
         os_len = `OS_NORMAL;
      end
   end

   // pin synchroniser: a level counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         rxd_s3 <= 1'b1;
         rxd_q <= 1'b1;
      end else begin
         rxd_s1 <= rxd;
         rxd_s2 <= rxd_s1;
         rxd_s3 <= rxd_s2;
         if (rxd_s2 == rxd_s3) begin
            rxd_q <= rxd_s3;
         end
      end
   end
   assign rx_pin_owned = ctrl_q.receiver_enable;

   serial_rx_shift u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .os_tick(os_tick),
      .os_len(os_len),
      .cfg(cfg),
      .enable(ctrl_q.receiver_enable),
      .rxd(rxd_q),
      .start_seen(rx_start),
      .valid(rx_valid),
      .entry(rx_entry),
      .stop_bit(rx_stop)
   );

   // address indication: ninth bit, or first stop bit for short frames
   assign rx_valid_f = rx_valid && !(multiproc_q &&
      !((cfg.nbits == 4'h9) ? rx_entry.ninth : rx_stop));

   // receive fifo, with a third character parked as in the shifter
   assign pop = rd_go && (araddr == `OFS_DATA) && (rx_count_q != 2'h0);
   assign push_pend = pop && pend_valid_q;
   assign rx_take = rx_valid_f && !pend_valid_q;
   assign push = push_pend || (rx_take && (rx_count_q != 2'h2 || pop));
   assign push_entry = push_pend ? pend_q : rx_entry;
   assign head = fifo_q[rd_ptr_q];
   generate
      for (genvar e = 0; e < 2; e++) begin : g_entry
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               fifo_q[e] <= '0;
            end else if (push && wr_ptr_q == 1'(e)) begin
               fifo_q[e] <= push_entry;
            end
         end
      end
   endgenerate
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q.receiver_enable) begin
         rx_count_q <= 2'h0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         pend_valid_q <= 1'b0;
      end else begin
         rx_count_q <= rx_count_q + {1'b0, push} - {1'b0, pop};
         wr_ptr_q <= wr_ptr_q ^ push;
         rd_ptr_q <= rd_ptr_q ^ pop;
         if (rx_take && rx_count_q == 2'h2 && !pop) begin
            pend_valid_q <= 1'b1;
         end else if (push_pend) begin
            pend_valid_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= '0;
      end else if (rx_take && rx_count_q == 2'h2 && !pop) begin
         pend_q <= rx_entry;
      end
   end
   // overrun: set wins over the clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q.receiver_enable) begin
         dor_q <= 1'b0;
      end else if (rx_start && pend_valid_q) begin
         dor_q <= 1'b1;
      end else if (pop) begin
         dor_q <= 1'b0;
      end
   end

   // transmit buffer; writes while full are dropped
   // a disabled transmitter still drains what it holds
   assign tx_load = tx_buf_full_q && tx_idle &&
      (ctrl_q.transmitter_enable || tx_own_q);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_buf_full_q <= 1'b0;
         tx_buf_q <= 9'h000;
      end else if (wr_data && !tx_buf_full_q) begin
         tx_buf_full_q <= 1'b1;
         tx_buf_q <= {ctrl_q.tx_ninth_bit, wdata_q[7:0]};
      end else if (tx_load) begin
         tx_buf_full_q <= 1'b0;
      end
   end

   serial_tx_shift u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .os_tick(os_tick),
      .os_len(os_len),
      .cfg(cfg),
      .load(tx_load),
      .load_data(tx_buf_q),
      .idle(tx_idle),
      .done(tx_done),
      .txd(tx_line)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txc_q <= 1'b0;
      end else if (tx_done && !tx_buf_full_q) begin
         txc_q <= 1'b1;
      end else if (tx_irq_ack ||
                   (wr_status && wdata_q[`POS_TX_COMPLETE])) begin
         txc_q <= 1'b0;
      end
   end
   // pin stays claimed until the last frame has left
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_own_q <= 1'b0;
      end else if (ctrl_q.transmitter_enable) begin
         tx_own_q <= 1'b1;
      end else if (tx_idle && !tx_buf_full_q) begin
         tx_own_q <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_q <= 1'b1;
      end else begin
         txd_q <= tx_own_q ? tx_line : 1'b1;
      end
   end
   assign txd = txd_q;
   assign txd_oe = tx_own_q;

   assign rx_irq_req = global_irq_en && ctrl_q.rx_complete_irq_en
      && (rx_count_q != 2'h0);
   assign tx_irq_req = global_irq_en && ctrl_q.tx_complete_irq_en
      && txc_q;
   assign empty_irq_req = global_irq_en && ctrl_q.tx_empty_irq_en
      && !tx_buf_full_q;

   // bus write side: address and data may arrive in either order
   assign awready = !aw_hold_q && !bvalid;
   assign wready = !w_hold_q && !bvalid;
   assign wr_go = aw_hold_q && w_hold_q;
   assign wr_en = wr_go && wstrb_q[0];
   assign wr_data = wr_en && awaddr_q == `OFS_DATA;
   assign wr_status = wr_en && awaddr_q == `OFS_STATUS_A;
   assign wr_ctrl = wr_en && awaddr_q == `OFS_CONTROL_B;
   assign wr_fmt = wr_en && awaddr_q == `OFS_FORMAT;
   assign wr_baud = wr_en && awaddr_q == `OFS_BAUD;
   assign wr_map = awaddr_q == `OFS_DATA || awaddr_q == `OFS_STATUS_A ||
      awaddr_q == `OFS_CONTROL_B || awaddr_q == `OFS_FORMAT ||
      awaddr_q == `OFS_BAUD;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
      end else if (awvalid && awready) begin
         aw_hold_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (wr_go) begin
         aw_hold_q <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         w_hold_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wr_go) begin
         w_hold_q <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else if (wr_go) begin
         bvalid <= 1'b1;
         bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // software-written control state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         double_speed_q <= 1'b0;
         multiproc_q <= 1'b0;
      end else if (wr_status) begin
         double_speed_q <= wdata_q[1];
         multiproc_q <= wdata_q[0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `RST_CONTROL_B;
      end else if (wr_ctrl) begin
         ctrl_q <= control_b_type'(wdata_q[7:0]);
         ctrl_q.rx_ninth_bit <= 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_q <= `RST_FORMAT;
      end else if (wr_fmt && wdata_q[`POS_REG_SELECT]) begin
         fmt_q <= frame_format_type'(wdata_q[7:0]);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_q <= `RST_BAUD;
      end else if (wr_baud) begin
         baud_q <= wdata_q[11:0];
      end
   end

   // bus read side; a read of the data location pops the fifo
   assign arready = !rvalid;
   assign rd_go = arvalid && arready;
   assign rd_map = araddr == `OFS_DATA || araddr == `OFS_STATUS_A ||
      araddr == `OFS_CONTROL_B || araddr == `OFS_FORMAT ||
      araddr == `OFS_BAUD;
   assign status_rd = {rx_count_q != 2'h0, txc_q, !tx_buf_full_q,
      (rx_count_q != 2'h0) && head.fe, dor_q,
      (rx_count_q != 2'h0) && head.pe,
      double_speed_q, multiproc_q};
   always_comb begin
      rd_word = 32'h0000_0000;
      case (araddr)
         `OFS_DATA: rd_word[7:0] = head.data;
         `OFS_STATUS_A: rd_word[7:0] = status_rd;
         `OFS_CONTROL_B: begin
            rd_word[7:0] = ctrl_q;
            rd_word[1] = (rx_count_q != 2'h0) && head.ninth;
         end
         `OFS_FORMAT: begin
            rd_word[7:0] = fmt_q;
            rd_word[`POS_REG_SELECT] = 1'b1;
         end
         `OFS_BAUD: rd_word[11:0] = baud_q;
         default: rd_word = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end else if (rd_go) begin
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_rx_flush:
   assert property (!ctrl_q.receiver_enable |=> rx_count_q == 2'h0 && !dor_q)
      else $error("receive buffer not flushed");
   chk_rx_last_pop:
   assert property (pop && rx_count_q == 2'h1 && !push |=> rx_irq_req == 1'b0
      && rx_count_q == 2'h0) else $error("receive flag left after last read");
   chk_txc_set:
   assert property (tx_done && !tx_buf_full_q |=> txc_q)
      else $error("tx complete not set");
   chk_txc_ack:
   assert property (tx_irq_ack && !tx_done |=> !txc_q)
      else $error("tx complete not cleared by service");
   chk_full_ignore:
   assert property (wr_data && tx_buf_full_q && !tx_load
      |=> tx_buf_full_q && $stable(tx_buf_q))
      else $error("full buffer overwritten");
   chk_irq_gate:
   assert property (tx_irq_req |-> global_irq_en && txc_q)
      else $error("interrupt without its flag");
   chk_pin_release:
   assert property ($fell(tx_own_q)
      |-> $past(tx_idle) && !$past(tx_buf_full_q))
      else $error("tx pin dropped with data pending");
   chk_fmt_select:
   assert property (wr_fmt && !wdata_q[`POS_REG_SELECT] |=> $stable(fmt_q))
      else $error("format written without select");
   chk_overrun_set:
   assert property (rx_start && pend_valid_q && ctrl_q.receiver_enable
      |=> dor_q) else $error("overrun missed");
   chk_speed_div:
   assert property (!fmt_q.sync_mode_select && double_speed_q
      |-> os_len == 5'h08) else $error("double speed divider wrong");
   cov_rx_push: cover property (rx_valid_f && rx_count_q == 2'h1);
   cov_overrun: cover property ($rose(dor_q));
   cov_tx_done: cover property (tx_done && !tx_buf_full_q);
endmodule // serial_port_control_status
`default_nettype wire

/* verification/serial_station.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_station (
   input wire logic aclk,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got;
   // line idles high between frames
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (16) @(posedge aclk);
      end
      rxd <= 1'b1;
   endtask
   // sample mid bit, start bit skipped
   always begin
      @(negedge txd);
      repeat (24) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         got[i] = txd;
         repeat (16) @(posedge aclk);
      end
   end
endmodule // serial_station
`default_nettype wire

/* verification/serial_port_control_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port_control_status_tb;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, rxd, txd, txd_oe;
   logic rx_pin_owned, global_irq_en, tx_irq_ack;
   logic rx_irq_req, tx_irq_req, empty_irq_req;
   logic [31:0] awaddr, wdata, araddr, rdata, v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   serial_port_control_status i_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .rxd(rxd),
      .rx_pin_owned(rx_pin_owned), .txd(txd), .txd_oe(txd_oe),
      .global_irq_en(global_irq_en), .tx_irq_ack(tx_irq_ack),
      .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
      .empty_irq_req(empty_irq_req)
   );
   serial_station i_station (.aclk(aclk), .txd(txd), .rxd(rxd));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask
   // each channel released at the rising edge that takes it
   task automatic wr(logic [31:0] a, logic [31:0] d);
      logic aw_left, w_left;
      aw_left = 1'b1;
      w_left = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw_left || w_left) begin
         @(posedge aclk);
         if (aw_left && awready) begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_left && wready) begin
            w_left = 1'b0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(logic [31:0] a, output logic [31:0] d);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(string n, logic [31:0] a, logic [31:0] e);
      rd(a, v);
      chk(n, v, e);
   endtask
   // polling, the timeout bounds it
   task automatic wait_txc;
      do rd(`OFS_STATUS_A, v); while (v[6] !== 1'b1);
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_of_test;
      end
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, tx_irq_ack} = '0;
      {awaddr, wdata, araddr} = '0;
      {aresetn, global_irq_en} = '0;
      wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc("status", `OFS_STATUS_A, 32'h20);
      rc("ctrl", `OFS_CONTROL_B, 32'h00);
      rc("fmt", `OFS_FORMAT, 32'h86);
      wr(`OFS_FORMAT, 32'h06);
      rc("fmt", `OFS_FORMAT, 32'h86);
      rd(32'h20, v);
      chk("resp", rs, `RESP_SLVERR);
      wr(32'h20, 32'h0000_00FF);
      chk("bresp", rs, `RESP_SLVERR);
      wr(`OFS_CONTROL_B, 32'h18);
      chk("bresp", rs, `RESP_OKAY);
      chk("rx_own", rx_pin_owned, 1'b1);
      i_station.send(8'hA5, 1'b1);
      i_station.send(8'h3C, 1'b0);
      repeat (8) @(posedge aclk);
      rc("status", `OFS_STATUS_A, 32'hA0);
      rc("data", `OFS_DATA, 32'hA5);
      rc("status", `OFS_STATUS_A, 32'hB0);
      rc("data", `OFS_DATA, 32'h3C);
      rc("status", `OFS_STATUS_A, 32'h20);
      // two buffered, one parked, fourth start overruns
      for (int i = 0; i < 4; i++) begin
         i_station.send(8'h11, 1'b1);
      end
      repeat (8) @(posedge aclk);
      rc("status", `OFS_STATUS_A, 32'hA8);
      wr(`OFS_CONTROL_B, 32'h08);
      rc("status", `OFS_STATUS_A, 32'h20);
      wr(`OFS_STATUS_A, 32'h01);
      wr(`OFS_CONTROL_B, 32'h18);
      i_station.send(8'h77, 1'b0);
      i_station.send(8'h3C, 1'b1);
      repeat (16) @(posedge aclk);
      rc("status", `OFS_STATUS_A, 32'hA1);
      rc("data", `OFS_DATA, 32'h3C);
      global_irq_en <= 1'b1;
      wr(`OFS_STATUS_A, 32'h00);
      wr(`OFS_CONTROL_B, 32'h9D);
      i_station.send(8'hC3, 1'b1);
      repeat (24) @(posedge aclk);
      chk("rx_irq", rx_irq_req, 1'b1);
      rc("ctrl", `OFS_CONTROL_B, 32'h9F);
      rc("data", `OFS_DATA, 32'hC3);
      wr(`OFS_CONTROL_B, 32'h68);
      chk("empty_irq", empty_irq_req, 1'b1);
      wr(`OFS_DATA, 32'h5A);
      wait_txc;
      chk("line", i_station.got, 32'h5A);
      chk("tx_irq", tx_irq_req, 1'b1);
      tx_irq_ack <= 1'b1;
      @(posedge aclk);
      tx_irq_ack <= 1'b0;
      rc("status", `OFS_STATUS_A, 32'h20);
      wr(`OFS_DATA, 32'hC3);
      wr(`OFS_CONTROL_B, 32'h00);
      chk("oe", txd_oe, 1'b1);
      wait_txc;
      chk("oe", txd_oe, 1'b0);
      chk("line", i_station.got, 32'hC3);
      wr(`OFS_STATUS_A, 32'h40);
      rc("status", `OFS_STATUS_A, 32'h20);
      end_of_test;
   end
endmodule // serial_port_control_status_tb
`default_nettype wire
